// ### tb/bpf_guard_asserts.sv
`timescale 1ns/10ps
// ****
// port checks
// ****
module bpf_guard_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic addr_strobe_in,
  input wire logic ext_addr_strobe,
  input wire logic mem_not_io,
  input wire logic read_not_write,
  input wire logic xlate_present,
  input wire logic guard_present,
  input wire logic xlate_ok,
  input wire logic protect_fault_n,
  input wire logic guard_result_valid_n,
  input wire logic page_parity_fault_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence io_cycle;
    (!mem_not_io && addr_strobe_in) [*8];
  endsequence
  sequence guard_only;
    guard_present && !xlate_present;
  endsequence
  strobe_low_fault_a: assert property (
    !addr_strobe_in [*5] |-> !protect_fault_n)
    else $error("fault released while strobe low");
  io_refused_a: assert property (
    io_cycle |-> protect_fault_n && guard_result_valid_n)
    else $error("io cycle checked");
  io_no_parity_a: assert property (
    io_cycle |-> page_parity_fault_n)
    else $error("parity fault on io cycle");
  no_guard_valid_a: assert property (
    (!guard_present) [*8] |-> guard_result_valid_n)
    else $error("valid low without protection");
  read_pass_a: assert property (
    ($fell(guard_result_valid_n) and guard_only and read_not_write)
    |-> protect_fault_n)
    else $error("read flagged");
  bad_xlate_a: assert property (
    (xlate_present && !xlate_ok) [*8] |-> !protect_fault_n)
    else $error("fault released on bad translation");
  xlate_wait_a: assert property (
    $fell(guard_result_valid_n) && xlate_present
    |-> $past(ext_addr_strobe, 3))
    else $error("check ahead of extended strobe");
  fault_after_check_a: assert property (
    $rose(protect_fault_n) && guard_present && mem_not_io
    |-> !guard_result_valid_n)
    else $error("fault released before check");
  reset_state_a: assert property (disable iff (1'b0)
    !rst_n |=> !protect_fault_n && guard_result_valid_n
    && page_parity_fault_n)
    else $error("bad reset outputs");
endmodule

// ### tb/bpf_host_model.sv
`timescale 1ns/10ps
// ****
// host bus model
// ****
module bpf_host_model (
  input wire logic core_clk,
  input wire logic guard_result_valid_n,
  output logic addr_strobe_in,
  output logic ext_addr_strobe,
  output logic mem_not_io,
  output logic read_not_write,
  output logic operand_not_instruction,
  output logic dma_active,
  output logic [15:0] cpu_address,
  output logic [19:0] extended_phys_address,
  output logic [3:0] address_state,
  output logic [3:0] processor_state
);
  initial begin
    addr_strobe_in = 1'b0;
    ext_addr_strobe = 1'b0;
    {mem_not_io, read_not_write} = 2'h3;
    {operand_not_instruction, dma_active} = 2'h2;
    cpu_address = 16'h0000;
    extended_phys_address = 20'h00000;
    {address_state, processor_state} = 8'h00;
  end
  // k is {mem, read, operand, dma}; lat 99 means no result seen
  task automatic cycle(input logic [3:0] k, input logic [19:0] a,
                       output int lat);
    @(negedge core_clk);
    {mem_not_io, read_not_write} = k[3:2];
    {operand_not_instruction, dma_active} = k[1:0];
    address_state = k[0] ? 4'h5 : 4'h0;
    processor_state = k[0] ? 4'hA : 4'h0;
    cpu_address = a[15:0];
    extended_phys_address = a;
    addr_strobe_in = 1'b1;
    @(negedge core_clk);
    ext_addr_strobe = 1'b1;
    lat = 99;
    for (int i = 1; i < 20 && lat == 99; i++) begin
      @(negedge core_clk);
      if (guard_result_valid_n === 1'b0) lat = i;
    end
  endtask
  // released bus must not keep showing the old address
  task automatic release_bus();
    @(negedge core_clk);
    addr_strobe_in = 1'b0;
    ext_addr_strobe = 1'b0;
    cpu_address = ~cpu_address;
    extended_phys_address = ~extended_phys_address;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

// ### tb/tb_bpf_guard_unit.sv
`timescale 1ns/10ps
module tb_bpf_guard_unit;
  typedef struct packed {logic [3:0] k; logic [19:0] a; logic f;} bpf_row_t;
  // {mem, read, operand, dma}, address, expected fault_n
  localparam bpf_row_t ROWS [9] = '{
    '{4'hA, 20'h00000, 1'b0}, '{4'hA, 20'h03C00, 1'b0},
    '{4'hA, 20'h00400, 1'b1}, '{4'hA, 20'h03800, 1'b1},
    '{4'hE, 20'h00000, 1'b1}, '{4'hC, 20'h03C00, 1'b1},
    '{4'h9, 20'h00000, 1'b0}, '{4'hD, 20'h03C00, 1'b1},
    '{4'hA, 20'h10000, 1'b0}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic xlate_present = 1'b0;
  logic guard_present = 1'b1;
  logic xlate_ok = 1'b1;
  logic page_parity_bad = 1'b0;
  logic guard_wr_en = 1'b0;
  logic [15:0] guard_wr_word = 16'h8001;
  logic addr_strobe_in, ext_addr_strobe, mem_not_io, read_not_write;
  logic operand_not_instruction, dma_active;
  logic [15:0] cpu_address;
  logic [19:0] extended_phys_address;
  logic [3:0] address_state, processor_state;
  logic protect_fault_n, guard_result_valid_n, page_parity_fault_n;
  logic [7:0] xlate_tag;
  int failures = 0;
  int comparisons = 0;
  int lat, lat2;
  always #10 core_clk = ~core_clk;
  bpf_guard_unit uut (.core_clk, .rst_n, .addr_strobe_in,
    .ext_addr_strobe, .mem_not_io, .read_not_write,
    .operand_not_instruction, .dma_active, .cpu_address,
    .extended_phys_address, .address_state, .processor_state,
    .xlate_present, .guard_present, .xlate_ok, .page_parity_bad,
    .guard_wr_en, .guard_wr_word, .protect_fault_n,
    .guard_result_valid_n, .page_parity_fault_n, .xlate_tag);
  bpf_host_model host (.core_clk, .guard_result_valid_n,
    .addr_strobe_in, .ext_addr_strobe, .mem_not_io, .read_not_write,
    .operand_not_instruction, .dma_active, .cpu_address,
    .extended_phys_address, .address_state, .processor_state);
  // ****
  // checking
  // ****
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("BAD %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  // a missing result ends the run rather than hanging
  task automatic acc(input logic [3:0] k, input logic [19:0] a,
                     input logic want);
    host.cycle(k, a, lat);
    if (want && lat == 99) begin
      failures++;
      $display("BAD %0t no result", $time);
      end_sim();
    end
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    chk1(protect_fault_n, 1'b0);
    chk1(guard_result_valid_n, 1'b1);
    chk1(page_parity_fault_n, 1'b1);
    rst_n = 1'b1;
    for (int i = 0; i < 256; i++) begin
      host.cycle(4'hE, {i[5:0], 14'h0000}, lat);
      host.release_bus();
    end
    acc(4'hA, 20'h00000, 1'b1);
    chk1(protect_fault_n, 1'b1);
    guard_wr_en = 1'b1;
    @(negedge core_clk);
    guard_wr_en = 1'b0;
    host.release_bus();
    foreach (ROWS[i]) begin
      acc(ROWS[i].k, ROWS[i].a, 1'b1);
      chk1(protect_fault_n, ROWS[i].f);
      host.release_bus();
    end
    acc(4'hA, 20'h04000, 1'b1);
    lat2 = lat;
    host.release_bus();
    acc(4'hA, 20'h04400, 1'b1);
    chk_n(lat2, lat + bpf_pkg::MISS_WAIT);
    host.release_bus();
    guard_present = 1'b0;
    acc(4'hA, 20'h00000, 1'b0);
    chk1(guard_result_valid_n, 1'b1);
    host.release_bus();
    guard_present = 1'b1;
    xlate_present = 1'b1;
    acc(4'hA, 20'h10000, 1'b1);
    chk1(protect_fault_n, 1'b1);
    chk1(xlate_tag === 8'h10, 1'b1);
    host.release_bus();
    xlate_ok = 1'b0;
    acc(4'hE, 20'h10000, 1'b0);
    chk1(protect_fault_n, 1'b0);
    host.release_bus();
    xlate_ok = 1'b1;
    page_parity_bad = 1'b1;
    acc(4'hE, 20'h10000, 1'b0);
    chk1(page_parity_fault_n, 1'b0);
    host.release_bus();
    acc(4'h6, 20'h10000, 1'b0);
    chk1(page_parity_fault_n, 1'b1);
    chk1(protect_fault_n, 1'b1);
    host.release_bus();
    chk1(protect_fault_n, 1'b0);
    end_sim();
  end
endmodule
bind bpf_guard_unit bpf_guard_asserts chk (.core_clk, .rst_n,
  .addr_strobe_in, .ext_addr_strobe, .mem_not_io, .read_not_write,
  .xlate_present, .guard_present, .xlate_ok, .protect_fault_n,
  .guard_result_valid_n, .page_parity_fault_n);

// ### verilog/bpf_guard_store.sv
`timescale 1ns/10ps
module bpf_guard_store #(
  parameter int unsigned RW = bpf_pkg::REGION_W
) (
  input wire logic core_clk,
  input wire logic [RW-1:0] rd_region,
  output logic [bpf_pkg::GUARD_W-1:0] rd_word,
  input wire logic wr_en,
  input wire logic [RW-1:0] wr_region,
  input wire logic [bpf_pkg::GUARD_W-1:0] wr_word
);
  // one guard word per 16K region; no reset, cleared by the sweep
  logic [bpf_pkg::GUARD_W-1:0] mem [0:(1<<RW)-1];
  logic [bpf_pkg::GUARD_W-1:0] rd_r;
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_region] <= wr_word;
    end
    rd_r <= mem[rd_region];
  end
  assign rd_word = rd_r;
endmodule

// ### verilog/bpf_guard_unit.sv
`timescale 1ns/10ps
module bpf_guard_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic addr_strobe_in,
  input wire logic ext_addr_strobe,
  input wire logic mem_not_io,
  input wire logic read_not_write,
  input wire logic operand_not_instruction,
  input wire logic dma_active,
  input wire logic [bpf_pkg::CPU_AW-1:0] cpu_address,
  input wire logic [bpf_pkg::PHYS_AW-1:0] extended_phys_address,
  input wire logic [bpf_pkg::STATE_W-1:0] address_state,
  input wire logic [bpf_pkg::STATE_W-1:0] processor_state,
  input wire logic xlate_present,
  input wire logic guard_present,
  input wire logic xlate_ok,
  input wire logic page_parity_bad,
  input wire logic guard_wr_en,
  input wire logic [bpf_pkg::GUARD_W-1:0] guard_wr_word,
  output logic protect_fault_n,
  output logic guard_result_valid_n,
  output logic page_parity_fault_n,
  output logic [bpf_pkg::PAGE_W-1:0] xlate_tag
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int unsigned SW = 8 + 2 * bpf_pkg::STATE_W;
  logic [SW-1:0] s_in;
  logic [SW-1:0] s_q;
  logic as_s, eas_s, mem_s, rd_s, op_s, dma_s, xp_s, gp_s;
  logic [bpf_pkg::STATE_W-1:0] ast_s, pst_s;
  assign s_in = {addr_strobe_in, ext_addr_strobe, mem_not_io,
                 read_not_write, operand_not_instruction, dma_active,
                 xlate_present, guard_present, address_state,
                 processor_state};
  assign {as_s, eas_s, mem_s, rd_s, op_s, dma_s, xp_s, gp_s, ast_s,
          pst_s} = s_q;
  bpf_sync #(.W(SW)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(s_in),
    .q(s_q)
  );
  logic [bpf_pkg::CPU_AW-1:0] ca_m_r, ca_r;
  logic [bpf_pkg::PHYS_AW-1:0] ea_m_r, ea_r;
  logic ok_m_r, ok_r, par_m_r, par_r;
  always_ff @(posedge core_clk) begin
    ca_m_r <= cpu_address;
    ca_r <= ca_m_r;
    ea_m_r <= extended_phys_address;
    ea_r <= ea_m_r;
    ok_m_r <= xlate_ok;
    ok_r <= ok_m_r;
    par_m_r <= page_parity_bad;
    par_r <= par_m_r;
  end
  // ****************************************************************
  // address selection and guard store
  // ****************************************************************
  logic [bpf_pkg::PHYS_AW-1:0] phys;
  logic [bpf_pkg::REGION_W-1:0] region;
  logic [3:0] blk;
  logic [bpf_pkg::GUARD_W-1:0] store_word;
  logic [bpf_pkg::CLEAR_W-1:0] clr_r, clr_nxt;
  logic clearing;
  always_comb begin
    // no translation: processor address zero-extended
    phys = xp_s ? ea_r
         : {{(bpf_pkg::PHYS_AW - bpf_pkg::CPU_AW){1'b0}}, ca_r};
    region = phys[bpf_pkg::PHYS_AW-1:bpf_pkg::REGION_LSB];
    blk = phys[bpf_pkg::REGION_LSB-1:bpf_pkg::BLOCK_LSB];
  end
  assign clearing = clr_r < bpf_pkg::CLEAR_W'(bpf_pkg::CLEAR_CYCLES);
  bpf_guard_store u_store (
    .core_clk(core_clk),
    .rd_region(region),
    .rd_word(store_word),
    .wr_en(clearing | guard_wr_en),
    .wr_region(clearing ? clr_r[bpf_pkg::REGION_W-1:0] : region),
    .wr_word(clearing ? bpf_pkg::GUARD_RST : guard_wr_word)
  );
  // ****************************************************************
  // sequencer
  // ****************************************************************
  bpf_pkg::bpf_state_t st_r, st_nxt;
  logic as_d_r, as_d_nxt;
  logic [bpf_pkg::PAGE_W-1:0] tc_r [2];
  logic [bpf_pkg::PAGE_W-1:0] tc_nxt [2];
  logic [1:0] tcv_r, tcv_nxt;
  logic [bpf_pkg::REGION_W-1:0] gtag_r, gtag_nxt;
  logic gv_r, gv_nxt;
  logic [bpf_pkg::GUARD_W-1:0] gw_r, gw_nxt;
  logic pf_r, pf_nxt, vld_r, vld_nxt, par_n_r, par_n_nxt;
  logic [bpf_pkg::PAGE_W-1:0] tag_r, tag_nxt;
  logic sel, prot_bit, as_rise, vio;
  logic [bpf_pkg::PAGE_W-1:0] page;
  always_comb begin
    // dma: read/write picks cache cpu: operand/instr
    sel = dma_s ? rd_s : op_s;
    page = phys[bpf_pkg::PHYS_AW-1:bpf_pkg::PAGE_LSB];
    // msb guards the lowest 1K block of the region
    prot_bit = gw_r[~blk];
    // only writes are checked
    vio = prot_bit & ~rd_s;
    as_rise = as_s & ~as_d_r;
    st_nxt = st_r;
    as_d_nxt = as_s;
    tc_nxt = tc_r;
    tcv_nxt = tcv_r;
    gtag_nxt = gtag_r;
    // a new guard word makes the cached copy stale
    gv_nxt = gv_r & ~clearing & ~guard_wr_en;
    gw_nxt = gw_r;
    pf_nxt = pf_r;
    vld_nxt = vld_r;
    par_n_nxt = par_n_r;
    tag_nxt = tag_r;
    clr_nxt = clr_r;
    // sweep advances one entry per strobe cycle
    if (clearing && as_rise) begin
      clr_nxt = clr_r + bpf_pkg::CLEAR_W'(1);
    end
    case (st_r)
      bpf_pkg::BPF_IDLE: begin
        if (as_rise && !mem_s) begin
          st_nxt = bpf_pkg::BPF_DONE;
          pf_nxt = 1'b1; // io cycle releases after strobe rise
        end else if (as_rise) begin
          st_nxt = xp_s ? bpf_pkg::BPF_XLATE : bpf_pkg::BPF_GFILL;
        end
      end
      bpf_pkg::BPF_XLATE: begin
        // wait for extended strobe before checking
        if (eas_s) begin
          // parity only on memory cycles
          par_n_nxt = ~par_r;
          if (tcv_r[sel] && tc_r[sel] == page) begin
            st_nxt = bpf_pkg::BPF_GFILL;
          end else begin
            st_nxt = bpf_pkg::BPF_XFILL; // one wait on miss
          end
        end
      end
      bpf_pkg::BPF_XFILL: begin
        tc_nxt[sel] = page;
        tcv_nxt[sel] = 1'b1;
        tag_nxt = page;
        st_nxt = bpf_pkg::BPF_GFILL; // refill before release
      end
      bpf_pkg::BPF_GFILL: begin
        if (!ok_r && xp_s) begin
          st_nxt = bpf_pkg::BPF_DONE; // bad translation stays low
        end else if (!gp_s) begin
          pf_nxt = 1'b1; // translation only
          st_nxt = bpf_pkg::BPF_DONE;
        end else if (gv_r && gtag_r == region) begin
          st_nxt = bpf_pkg::BPF_CHECK; // hit path is shortest
        end else begin
          gw_nxt = store_word; // region reload wait
          gtag_nxt = region;
          gv_nxt = ~clearing & ~guard_wr_en;
        end
      end
      bpf_pkg::BPF_CHECK: begin
        pf_nxt = ~vio;
        vld_nxt = 1'b0;
        st_nxt = bpf_pkg::BPF_DONE;
      end
      bpf_pkg::BPF_DONE: begin
        if (!as_s) begin
          st_nxt = bpf_pkg::BPF_IDLE;
        end
      end
      default: st_nxt = bpf_pkg::BPF_IDLE;
    endcase
    // strobe low forces fault and clears result
    if (!as_s) begin
      // a cut cycle never leaves the sequencer waiting mid-check
      st_nxt = bpf_pkg::BPF_IDLE;
      pf_nxt = 1'b0;
      vld_nxt = 1'b1;
      par_n_nxt = 1'b1;
    end
    if (!gp_s) begin
      vld_nxt = 1'b1; // no protection unit: stays high
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= bpf_pkg::BPF_IDLE;
      as_d_r <= 1'b0;
      tc_r[0] <= '0;
      tc_r[1] <= '0;
      tcv_r <= 2'h0;
      gtag_r <= '0;
      gv_r <= 1'b0;
      gw_r <= bpf_pkg::GUARD_RST;
      pf_r <= 1'b0;
      vld_r <= 1'b1;
      par_n_r <= 1'b1;
      tag_r <= '0;
      clr_r <= '0;
    end else begin
      st_r <= st_nxt;
      as_d_r <= as_d_nxt;
      tc_r <= tc_nxt;
      tcv_r <= tcv_nxt;
      gtag_r <= gtag_nxt;
      gv_r <= gv_nxt;
      gw_r <= gw_nxt;
      pf_r <= pf_nxt;
      vld_r <= vld_nxt;
      par_n_r <= par_n_nxt;
      tag_r <= tag_nxt;
      clr_r <= clr_nxt;
    end
  end
  assign protect_fault_n = pf_r;
  assign guard_result_valid_n = vld_r;
  assign page_parity_fault_n = par_n_r;
  assign xlate_tag = tag_r;
endmodule

// ### verilog/bpf_pkg.sv
package bpf_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int unsigned PHYS_AW = 20;
  localparam int unsigned CPU_AW = 16;
  localparam int unsigned GUARD_W = 16;
  localparam int unsigned BLOCK_LSB = 10;
  localparam int unsigned REGION_LSB = 14;
  localparam int unsigned PAGE_LSB = 12;
  localparam int unsigned REGION_W = PHYS_AW - REGION_LSB;
  localparam int unsigned PAGE_W = PHYS_AW - PAGE_LSB;
  localparam int unsigned STATE_W = 4;
  // ****************************************************************
  // reset and timing
  // ****************************************************************
  localparam int unsigned CLEAR_CYCLES = 256;
  localparam int unsigned CLEAR_W = 9;
  localparam logic [GUARD_W-1:0] GUARD_RST = 16'h0000;
  localparam int unsigned MISS_WAIT = 1;
  // ****************************************************************
  // access sequencer states
  // ****************************************************************
  typedef enum logic [5:0] {
    BPF_IDLE   = 6'b000001,
    BPF_XLATE  = 6'b000010,
    BPF_XFILL  = 6'b000100,
    BPF_GFILL  = 6'b001000,
    BPF_CHECK  = 6'b010000,
    BPF_DONE   = 6'b100000
  } bpf_state_t;
endpackage

// ### verilog/bpf_sync.sv
`timescale 1ns/10ps
module bpf_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  // first stage is read only by the second
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule
